// File: dv/testbench.sv
// register-level bench for the dual serial block
`timescale 1ns/1ps
module testbench import ubf_pkg::*;;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [NCH-1:0] rx, tx;
  int err_count = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  ubf_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .receive_line(rx), .transmit_line(tx));
  ubf_remote rem0 (.core_clk(core_clk), .line_in(tx[0]), .line_out(rx[0]));
  ubf_remote rem1 (.core_clk(core_clk), .line_in(tx[1]), .line_out(rx[1]));
  initial forever #50 core_clk = ~core_clk;
  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic tmo(input bit t);
    if (t) begin
      err_count++;
      $display("wrong value wait expected done seen timeout");
      give_verdict();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 5000);
    while (!bvalid && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    r = bresp;
    bready <= 1'b0;
    tmo(n >= 5000);
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!arready && n < 5000);
    arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!rvalid && n < 5000);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n >= 5000);
  endtask : rdr
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk("bresp", RESP_OKAY, rs);
  endtask : w
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rdr(a, rd, rs);
    chk(nm, e, rd);
  endtask : rc
  task automatic frames(input int n);
    int k = 0;
    while (rem0.got_cnt + rem1.got_cnt < n && k < 25000) begin
      @(posedge core_clk);
      k++;
    end
    tmo(k >= 25000);
  endtask : frames
  task automatic flag_wait(input int b);
    int k = 0;
    rd = '0;
    while (!rd[b] && k < 200) begin
      rdr(ADDR_CTRL_A0, rd, rs);
      k++;
    end
    tmo(k >= 200);
  endtask : flag_wait
  initial begin
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    rc(ADDR_HIGH_NIB, 32'h0, "high reset");
    rc(ADDR_LOW_CH0, 32'h0, "low0 reset");
    w(ADDR_HIGH_NIB, 32'hFFFFFFA5);
    w(ADDR_LOW_CH0, 32'h1FF);
    rc(ADDR_HIGH_NIB, 32'hA5, "high");
    rc(ADDR_LOW_CH0, 32'hFF, "low0");
    wr(8'h40, 32'h1, rs);
    chk("bad bresp", RESP_SLVERR, rs);
    rdr(8'h40, rd, rs);
    chk("bad rresp", RESP_SLVERR, rs);
    chk("bad rdata", 32'h0, rd);
    // channel 0 divider 1: 32 clocks a bit
    w(ADDR_HIGH_NIB, 32'h10);
    w(ADDR_LOW_CH0, 32'h01);
    w(ADDR_DATA0, 32'h5B);
    repeat (400) @(posedge core_clk);
    chk("idle frames", 0, rem0.got_cnt);
    w(ADDR_CTRL_B0, 32'h08);
    frames(1);
    chk("tx data", 32'h5B, rem0.got_data);
    chk("start len", 32, rem0.start_len);
    chk("stop", 1, rem0.got_stop);
    // enable cleared with a character still buffered
    w(ADDR_DATA0, 32'h13);
    // wait until the first character has moved into the shift register
    flag_wait(CA_TXEMPTY);
    w(ADDR_DATA0, 32'h27);
    w(ADDR_CTRL_B0, 32'h00);
    frames(3);
    chk("drained", 32'h27, rem0.got_data);
    // ninth bit as odd parity of the byte
    rem0.nb = 9;
    w(ADDR_CTRL_B0, {31'h6, ~(^8'h81)});
    w(ADDR_DATA0, 32'h81);
    frames(4);
    chk("tx ninth", 32'h181, rem0.got_data);
    for (int b = 1; b >= 0; b--) begin
      rem0.send({b[0], 8'hA5});
      flag_wait(CA_RXFULL);
      rc(ADDR_CTRL_B0, {28'h0, 2'b11, b[0], 1'b1}, "rx ninth");
      rc(ADDR_DATA0, 32'hA5, "rx data");
    end
    // double speed: 16 clocks a bit, short spike ignored
    rem0.nb = 8;
    rem0.bt = 16;
    w(ADDR_CTRL_B0, 32'h08);
    w(ADDR_CTRL_A0, 32'h02);
    w(ADDR_DATA0, 32'h35);
    frames(5);
    chk("dbl start len", 16, rem0.start_len);
    chk("dbl data", 32'h35, rem0.got_data);
    rem0.spike(3);
    repeat (200) @(posedge core_clk);
    rc(ADDR_CTRL_A0, 32'h22, "after spike");
    rem0.send(9'h0C3);
    flag_wait(CA_RXFULL);
    rc(ADDR_DATA0, 32'hC3, "dbl rx");
    // channel 1 divider 256 from the shared upper nibble
    rem1.bt = 8 * 257;
    w(ADDR_LOW_CH1, 32'h00);
    w(ADDR_CTRL_A1, 32'h02);
    w(ADDR_CTRL_B1, 32'h08);
    w(ADDR_DATA1, 32'h01);
    frames(6);
    chk("ch1 start len", 8 * 257, rem1.start_len);
    chk("ch1 data", 32'h01, rem1.got_data);
    give_verdict();
  end
endmodule : testbench

// File: dv/ubf_remote.sv
// remote serial node: frame sender and frame decoder
`timescale 1ns/1ps
module ubf_remote (
  // clock
  input wire logic core_clk,
  // line
  input wire logic line_in,
  output logic line_out
);
  int bt = 32;
  int nb = 8;
  int got_cnt = 0;
  int start_len = 0;
  int n;
  logic [8:0] got_data;
  logic got_stop;
  initial line_out = 1'b1;
  // caller supplies the ninth bit; bit time is exact, no rate error
  task automatic send(input logic [8:0] d);
    for (int i = -1; i <= nb; i++) begin
      @(posedge core_clk);
      line_out <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : d[i];
      repeat (bt - 1) @(posedge core_clk);
    end
  endtask : send
  task automatic spike(input int len);
    @(posedge core_clk);
    line_out <= 1'b0;
    repeat (len) @(posedge core_clk);
    line_out <= 1'b1;
  endtask : spike
  // measures the start bit, so the first data bit must be one
  always begin
    @(negedge line_in);
    n = 0;
    while (line_in === 1'b0 && n < 70000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    start_len = n;
    got_data = '0;
    for (int i = 0; i < nb; i++) begin
      repeat ((i == 0) ? bt / 2 : bt) @(posedge core_clk);
      got_data[i] = line_in;
    end
    repeat (bt) @(posedge core_clk);
    got_stop = line_in;
    got_cnt++;
  end
endmodule : ubf_remote

// File: dv/ubf_top_assertions.sv
// bus and line checks for the dual serial block
`timescale 1ns/1ps
module ubf_top_chk import ubf_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // line
  input wire logic [NCH-1:0] transmit_line
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_DATA1
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  byte_wide_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  min_bit_a: assert property ($fell(transmit_line[0]) |=> !transmit_line[0] [*7])
    else $error("start bit too short");
  wr_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_c: cover property (s_axi_rvalid && s_axi_rready);
  tx_c: cover property ($fell(transmit_line[1]));
endmodule : ubf_top_chk

bind ubf_top ubf_top_chk i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .transmit_line(transmit_line));

// File: rtl/ubf_baud_gen.sv
// per-channel 12-bit down-counter that makes the sample tick
`timescale 1ns/1ps
module ubf_baud_gen import ubf_pkg::*; #(
  parameter int W = DIV_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // divider and tick
  input wire logic [W-1:0] divider,
  output logic tick
);
  logic [W-1:0] cnt_q;
  wire logic zero = (cnt_q == '0);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= zero ? divider : cnt_q - 1'b1;
      tick <= zero;
    end
  end
endmodule : ubf_baud_gen

// File: rtl/ubf_channel.sv
// one serial channel: transmitter with buffer and majority-voting receiver
`timescale 1ns/1ps
module ubf_channel import ubf_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control
  input wire logic tick,
  input wire ubf_cfg_t cfg,
  input wire logic wr_data,
  input wire logic [7:0] wdata,
  input wire logic rd_data,
  // line
  input wire logic rx_line,
  output logic tx_line,
  // state
  output ubf_stat_t stat
);
  // receive line synchroniser, change counts when stages 2 and 3 agree
  logic [2:0] sync_q;
  logic rx_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q <= 3'b111;
      rx_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], rx_line};
      if (sync_q[2] == sync_q[1]) rx_q <= sync_q[2];
    end
  end

  wire logic [3:0] last_tick = cfg.double_speed ? TICKS_DBL : TICKS_NORM;
  wire logic [3:0] nbits = cfg.nine_bit ? BITS_9 : BITS_8;

  // transmitter: buffer plus shift register
  logic [8:0] buf_q;
  logic buf_full_q;
  logic [10:0] sh_q;
  logic [3:0] tbit_q;
  logic [3:0] ttick_q;
  logic tbusy_q;
  // stays set after tx enable drops until shift register and buffer are both empty
  logic drain_q;
  // loads wait for a tick so the start bit is exactly one bit time long
  wire logic load = tick && !tbusy_q && buf_full_q && (cfg.tx_enable || drain_q);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_q <= '0;
      buf_full_q <= 1'b0;
      sh_q <= '1;
      tbit_q <= '0;
      ttick_q <= '0;
      tbusy_q <= 1'b0;
      drain_q <= 1'b0;
    end else begin
      drain_q <= cfg.tx_enable || (drain_q && (tbusy_q || buf_full_q));
      if (wr_data) begin
        buf_q <= {cfg.tx_ninth, wdata};
        buf_full_q <= 1'b1;
      end else if (load) begin
        buf_full_q <= 1'b0;
      end
      if (load) begin
        // ninth bit position doubles as stop in eight-bit mode
        sh_q <= cfg.nine_bit ? {1'b1, buf_q, 1'b0} : {2'b11, buf_q[7:0], 1'b0};
        tbusy_q <= 1'b1;
        tbit_q <= '0;
        ttick_q <= '0;
      end else if (tbusy_q && tick) begin
        // a started character always completes even after tx enable drops
        if (ttick_q == last_tick) begin
          ttick_q <= '0;
          sh_q <= {1'b1, sh_q[10:1]};
          if (tbit_q == nbits) tbusy_q <= 1'b0;
          tbit_q <= tbit_q + 1'b1;
        end else begin
          ttick_q <= ttick_q + 1'b1;
        end
      end
    end
  end

  // receiver
  ubf_rx_st_t st_q;
  logic [3:0] rtick_q;
  logic [3:0] rbit_q;
  logic [2:0] vote_q;
  logic [9:0] rsh_q;
  logic [8:0] rdat_q;
  logic rvalid_q;
  logic ferr_q;
  wire logic [3:0] m1 = cfg.double_speed ? D_MID1 : S_MID1;
  wire logic [3:0] m2 = cfg.double_speed ? D_MID2 : S_MID2;
  wire logic [3:0] m3 = cfg.double_speed ? D_MID3 : S_MID3;
  // majority of the two earlier votes and the current sample
  wire logic maj = (vote_q[1] & vote_q[0]) | (vote_q[1] & rx_q) | (vote_q[0] & rx_q);
  wire logic at_m3 = tick && (rtick_q == m3);
  wire logic bit_end = tick && (rtick_q == last_tick);
  wire logic last_bit = (rbit_q == nbits);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= RX_IDLE;
      rtick_q <= '0;
      rbit_q <= '0;
      vote_q <= '0;
      rsh_q <= '0;
      rdat_q <= '0;
      rvalid_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      if (tick && (rtick_q == m1 || rtick_q == m2)) vote_q <= {vote_q[1:0], rx_q};
      case (st_q)
        RX_IDLE: begin
          rtick_q <= 4'h1;
          if (tick && !rx_q) st_q <= RX_START;
        end
        RX_START: begin
          if (tick) rtick_q <= (rtick_q == last_tick) ? 4'h0 : rtick_q + 1'b1;
          if (at_m3 && maj) st_q <= RX_IDLE;
          else if (bit_end) begin
            st_q <= RX_DATA;
            rbit_q <= 4'h1;
          end
        end
        RX_DATA: begin
          if (tick) rtick_q <= (rtick_q == last_tick) ? 4'h0 : rtick_q + 1'b1;
          if (at_m3) begin
            rsh_q <= {maj, rsh_q[9:1]};
            if (last_bit) begin
              st_q <= RX_IDLE;
              rdat_q <= cfg.nine_bit ? rsh_q[9:1] : {1'b0, rsh_q[9:2]};
              ferr_q <= !maj;
            end
          end
          if (bit_end) rbit_q <= rbit_q + 1'b1;
        end
        default: st_q <= RX_IDLE;
      endcase
      // set wins over the read that clears
      if (st_q == RX_DATA && at_m3 && last_bit) rvalid_q <= 1'b1;
      else if (rd_data) rvalid_q <= 1'b0;
    end
  end

  assign tx_line = sh_q[0];
  assign stat = '{rx_data: rdat_q, rx_valid: rvalid_q, rx_frame_err: ferr_q,
                  tx_busy: tbusy_q, tx_take: !buf_full_q};
endmodule : ubf_channel

// File: rtl/ubf_pkg.sv
// constants, register map and types for the dual serial baud and frame block
// How it works
// - transmitter loads characters only while tx enable (control b bit 3) is one or a drain is pending
// - clearing tx enable finishes shift register and buffered character first
// - nine-bit bit (bit 2) selects nine data bits, else eight
// - ninth received bit lands in read-only control b bit 1
// - control b bit 0 is sent as ninth data bit
// - normal speed: baud is clock over sixteen times divider plus one
// - each channel has a 12-bit divider, values 0 to 4095
// - low eight divider bits sit in a per-channel register
// - double speed: baud is clock over eight times divider plus one
// - double speed: idle low sample counts as start edge, sample 1
// - start checked at samples 4,5,6 in double speed, 8,9,10 in normal speed; two highs reject as noise
// - data bits sampled at 4,5,6 in double speed, 8,9,10 in normal speed, majority taken
// - each bit shifts in as soon as its majority is decided
// - double speed makes each bit 8 sample ticks instead of 16
package ubf_pkg;
  localparam int DIV_W = 12;
  localparam int NCH = 2;
  // register byte addresses
  localparam logic [7:0] ADDR_HIGH_NIB = 8'h00;
  localparam logic [7:0] ADDR_LOW_CH0 = 8'h04;
  localparam logic [7:0] ADDR_LOW_CH1 = 8'h08;
  localparam logic [7:0] ADDR_CTRL_A0 = 8'h0C;
  localparam logic [7:0] ADDR_CTRL_B0 = 8'h10;
  localparam logic [7:0] ADDR_DATA0 = 8'h14;
  localparam logic [7:0] ADDR_CTRL_A1 = 8'h18;
  localparam logic [7:0] ADDR_CTRL_B1 = 8'h1C;
  localparam logic [7:0] ADDR_DATA1 = 8'h20;
  localparam logic [7:0] CH_STRIDE = 8'h0C;
  // control b fields
  localparam int CB_TXEN = 3;
  localparam int CB_NINE = 2;
  localparam int CB_RX8 = 1;
  localparam int CB_TX8 = 0;
  // control a fields
  localparam int CA_DBL = 1;
  localparam int CA_BUSY = 2;
  localparam int CA_RXFULL = 7;
  localparam int CA_TXEMPTY = 5;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // last sample tick index of a bit, vote ticks and stop bit index
  localparam logic [3:0] TICKS_NORM = 4'hF;
  localparam logic [3:0] TICKS_DBL = 4'h7;
  localparam logic [3:0] S_MID1 = 4'h7;
  localparam logic [3:0] S_MID2 = 4'h8;
  localparam logic [3:0] S_MID3 = 4'h9;
  localparam logic [3:0] D_MID1 = 4'h3;
  localparam logic [3:0] D_MID2 = 4'h4;
  localparam logic [3:0] D_MID3 = 4'h5;
  localparam logic [3:0] BITS_8 = 4'h9;
  localparam logic [3:0] BITS_9 = 4'hA;

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b11} ubf_rx_st_t;

  typedef struct packed {
    logic tx_enable;
    logic nine_bit;
    logic tx_ninth;
    logic double_speed;
  } ubf_cfg_t;

  typedef struct packed {
    logic [8:0] rx_data;
    logic rx_valid;
    logic rx_frame_err;
    logic tx_busy;
    logic tx_take;
  } ubf_stat_t;
endpackage : ubf_pkg

// File: rtl/ubf_top.sv
// dual serial channel with shared baud divider nibbles, AXI4-Lite registers
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ubf_top import ubf_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial lines
  input wire logic [NCH-1:0] receive_line,
  output logic [NCH-1:0] transmit_line
);
  logic [7:0] baud_divider_high_nibbles_q;
  logic [7:0] low_q [NCH];
  logic [3:0] cb_q [NCH];
  logic [NCH-1:0] dbl_q;
  logic [7:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic w_have_q;
  logic [NCH-1:0] tx_q;
  ubf_stat_t stat [NCH];
  logic [NCH-1:0] wr_data;
  logic [NCH-1:0] rd_data;

  wire logic do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
  wire logic do_rd = s_axi_arvalid && s_axi_arready;
  wire logic wb0 = s_axi_wstrb[0];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire logic [7:0] base = 8'(int'(CH_STRIDE) * g);
      wire logic [3:0] nib = baud_divider_high_nibbles_q[4*g +: 4];
      wire logic [DIV_W-1:0] div = {nib, low_q[g]};
      logic tick;
      ubf_cfg_t cfg;
      assign cfg = '{tx_enable: cb_q[g][CB_TXEN], nine_bit: cb_q[g][CB_NINE],
                     tx_ninth: cb_q[g][CB_TX8], double_speed: dbl_q[g]};
      assign wr_data[g] = do_wr && (awaddr_q == ADDR_DATA0 + base);
      assign rd_data[g] = do_rd && (s_axi_araddr == ADDR_DATA0 + base);
      ubf_baud_gen #(.W(DIV_W)) u_baud (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .divider(div),
        .tick(tick)
      );
      ubf_channel u_ch (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tick(tick),
        .cfg(cfg),
        .wr_data(wr_data[g]),
        .wdata(wdata_q[7:0]),
        .rd_data(rd_data[g]),
        .rx_line(receive_line[g]),
        .tx_line(tx_q[g]),
        .stat(stat[g])
      );
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          low_q[g] <= '0;
          cb_q[g] <= '0;
          dbl_q[g] <= 1'b0;
        end else if (do_wr && wb0) begin
          if (awaddr_q == (g == 0 ? ADDR_LOW_CH0 : ADDR_LOW_CH1)) low_q[g] <= wdata_q[7:0];
          if (awaddr_q == ADDR_CTRL_B0 + base) begin
            cb_q[g][CB_TXEN] <= wdata_q[CB_TXEN];
            cb_q[g][CB_NINE] <= wdata_q[CB_NINE];
            cb_q[g][CB_TX8] <= wdata_q[CB_TX8];
          end
          if (awaddr_q == ADDR_CTRL_A0 + base) dbl_q[g] <= wdata_q[CA_DBL];
        end
      end
    end
  endgenerate

  // read mux
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_HIGH_NIB: rd_mux[7:0] = baud_divider_high_nibbles_q;
      ADDR_LOW_CH0: rd_mux[7:0] = low_q[0];
      ADDR_LOW_CH1: rd_mux[7:0] = low_q[1];
      ADDR_CTRL_A0: rd_mux[7:0] = {stat[0].rx_valid, 1'b0, stat[0].tx_take,
                                   stat[0].rx_frame_err, 1'b0, stat[0].tx_busy, dbl_q[0], 1'b0};
      ADDR_CTRL_A1: rd_mux[7:0] = {stat[1].rx_valid, 1'b0, stat[1].tx_take,
                                   stat[1].rx_frame_err, 1'b0, stat[1].tx_busy, dbl_q[1], 1'b0};
      ADDR_CTRL_B0: rd_mux[3:0] = {cb_q[0][CB_TXEN], cb_q[0][CB_NINE], stat[0].rx_data[8],
                                   cb_q[0][CB_TX8]};
      ADDR_CTRL_B1: rd_mux[3:0] = {cb_q[1][CB_TXEN], cb_q[1][CB_NINE], stat[1].rx_data[8],
                                   cb_q[1][CB_TX8]};
      ADDR_DATA0: rd_mux[7:0] = stat[0].rx_data[7:0];
      ADDR_DATA1: rd_mux[7:0] = stat[1].rx_data[7:0];
      default: rd_hit = 1'b0;
    endcase
  end
  wire logic wr_hit = (awaddr_q <= ADDR_DATA1) && (awaddr_q[1:0] == 2'b00);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_divider_high_nibbles_q <= '0;
      awaddr_q <= '0;
      aw_have_q <= 1'b0;
      wdata_q <= '0;
      w_have_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
      transmit_line <= '1;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      transmit_line <= tx_q;
      // readies drop once a request is captured and return with its response handshake
      if (s_axi_awvalid && s_axi_awready) s_axi_awready <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready) s_axi_awready <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) s_axi_wready <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready) s_axi_wready <= 1'b1;
      if (do_rd) s_axi_arready <= 1'b0;
      else if (s_axi_rvalid && s_axi_rready) s_axi_arready <= 1'b1;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        w_have_q <= 1'b1;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_q == ADDR_HIGH_NIB && wb0) baud_divider_high_nibbles_q <= wdata_q[7:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : ubf_top
